// ===== src/cod_defs.vh
// Purpose: constants for the compact operand decoder
// Assumes: included by bare name from design files
// Notes: opcode values are chosen locally; field layouts are fixed
`ifndef COD_DEFS_VH
`define COD_DEFS_VH

// ==================================================
// Implicit and special register numbers
`define COD_REG_ZERO 5'h00
`define COD_REG_GP 5'h1c
`define COD_REG_SP 5'h1d
`define COD_REG_RA 5'h1f
`define COD_REG_S0 5'h10
`define COD_REG_S1 5'h11

// ==================================================
// Operand source select codes
`define COD_SRC_GPR 2'h0
`define COD_SRC_PC 2'h1
`define COD_SRC_UPPER 2'h2
`define COD_SRC_BOTTOM 2'h3

// ==================================================
// Operation codes seen by this decoder
`define COD_OP_NONE 5'h00
`define COD_OP_ADDI2 5'h01
`define COD_OP_MASKI 5'h02
`define COD_OP_SB 5'h03
`define COD_OP_SH 5'h04
`define COD_OP_SW 5'h05
`define COD_OP_COPY 5'h06
`define COD_OP_JR16 5'h07
`define COD_OP_LOAD_WORD_STACK_REL 5'h08
`define COD_OP_STORE_WORD_STACK_REL 5'h09
`define COD_OP_RDUP 5'h0a
`define COD_OP_RDBOT 5'h0b
`define COD_OP_LWGP 5'h0c
`define COD_OP_BEQZ16 5'h0d
`define COD_OP_B16 5'h0e
`define COD_OP_BRANCH_ZERO_NODELAY 5'h0f
`define COD_OP_BRANCH_NONZERO_NODELAY 5'h10
`define COD_OP_CALL_REG_SHORT_SLOT 5'h11
`define COD_OP_JALRSHB 5'h12
`define COD_OP_LOAD_WORD_SCALED_INDEX 5'h13
`define COD_OP_ADDIPC 5'h14
`define COD_OP_JALRS16 5'h15

// ==================================================
// Shift amounts and return offsets
`define COD_SHIFT_HALF 5'h01
`define COD_SHIFT_WORD 5'h02
`define COD_LINK_SHORT 32'h00000002

`endif

// ===== src/cod_reg_map.v
// Purpose: maps a 3-bit compact register code to a register number
// Assumes: purely combinational
// Notes: store_src selects the store-source set
`timescale 1ns/1ns
module cod_reg_map (
   // Code in
   input wire [2:0] code,
   input wire store_src,
   // Register out
   output reg [4:0] reg_num
);
`include "cod_defs.vh"

   // ==================================================
   // Decode; codes 2..7 pass straight through
   always @* begin
      case (code)
         3'h0: reg_num = store_src ? `COD_REG_ZERO : `COD_REG_S0; // RQ1 RQ2
         3'h1: reg_num = `COD_REG_S1; // RQ1 RQ2
         default: reg_num = {2'h0, code}; // RQ3
      endcase
   end
endmodule // cod_reg_map

// ===== src/cod_imm_expand.v
// Purpose: expands coded compact immediates
// Assumes: purely combinational
// Notes: results are full 32-bit values
`timescale 1ns/1ns
module cod_imm_expand (
   // Codes in
   input wire [2:0] add_code,
   input wire [3:0] mask_code,
   // Values out
   output reg [31:0] add_val,
   output reg [31:0] mask_val
);
`include "cod_defs.vh"

   // ==================================================
   // Add immediate table, -1 is sign-extended
   always @* begin
      case (add_code)
         3'h0: add_val = 32'hffffffff; // RQ8 RQ16
         3'h1: add_val = 32'h00000001;
         3'h2: add_val = 32'h00000004;
         3'h3: add_val = 32'h00000008;
         3'h4: add_val = 32'h0000000c;
         3'h5: add_val = 32'h00000010;
         3'h6: add_val = 32'h00000014;
         default: add_val = 32'h00000018;
      endcase
   end

   // ==================================================
   // Mask table, always zero-extended
   always @* begin
      case (mask_code)
         4'h0: mask_val = 32'h00000001; // RQ9 RQ16
         4'h1: mask_val = 32'h00000002;
         4'h2: mask_val = 32'h00000003;
         4'h3: mask_val = 32'h00000004;
         4'h4: mask_val = 32'h00000007;
         4'h5: mask_val = 32'h00000008;
         4'h6: mask_val = 32'h0000000f;
         4'h7: mask_val = 32'h00000010;
         4'h8: mask_val = 32'h0000001f;
         4'h9: mask_val = 32'h00000020;
         4'ha: mask_val = 32'h0000003f;
         4'hb: mask_val = 32'h00000040;
         4'hc: mask_val = 32'h00000080;
         4'hd: mask_val = 32'h000000ff;
         4'he: mask_val = 32'h00008000;
         default: mask_val = 32'h0000ffff;
      endcase
   end
endmodule // cod_imm_expand

// ===== src/cod_decoder.v
// Purpose: operand decode for compact instruction forms
// Assumes: fetch gives a pre-classified op code and raw instruction word
// Notes: one cycle of latency; outputs registered
// How it works
// RQ1: 3-bit codes 0,1 give 16,17; else 2-7
// RQ2: store source: 0 zero, 1 r17, 2-7
// RQ3: 3-bit codes reach only eight; copy reaches all
// RQ4: compact 5-bit fields reach any register
// RQ5: implicit global, stack, link are 28,29,31
// RQ6: PC-relative add: PC, 3-bit dest, 23-bit imm
// RQ7: product reads pick upper or bottom word
// RQ8: two-register add immediate table in order
// RQ9: mask immediate table of sixteen in order
// RQ10: zero branches: one register, 16-bit offset, no slot
// RQ11: register calls link past short slot
// RQ12: scaled load: base plus index times four
// RQ13: 5-bit fields encode register numbers linearly
// RQ14: compact branch offsets shift left one
// RQ15: stack word offsets shift left two
// RQ16: extend expanded immediates to 32 bits
`timescale 1ns/1ns
module cod_decoder (
   // Clock and reset
   input wire clk,
   input wire rst,
   // From fetch
   input wire in_valid,
   input wire [4:0] op,
   input wire [31:0] instr,
   input wire [31:0] pc,
   // Decoded operands
   output reg out_valid_ff,
   output reg [4:0] src_a_ff,
   output reg [4:0] src_b_ff,
   output reg [4:0] dest_ff,
   output reg dest_we_ff,
   output reg [1:0] src_sel_ff,
   output reg [31:0] imm_ff,
   output reg [4:0] imm_shift_ff,
   output reg [4:0] index_shift_ff,
   output reg no_delay_slot_ff,
   output reg [31:0] link_addr_ff,
   output reg link_we_ff
);
`include "cod_defs.vh"

   // ==================================================
   // Sign extension helper for a field of given width
   function [31:0] sext;
      input [22:0] v;
      input [4:0] w;
      reg [31:0] t;
      begin
         t = {9'h000, v};
         sext = t;
         // Width must stay within 1..23; the field's top bit is the sign
         if (v[w - 5'h01])
            sext = t | ~((32'h00000001 << w) - 32'h00000001);
      end
   endfunction

   // ==================================================
   // Compact field positions in the low halfword
   wire [2:0] f_rd3 = instr[9:7];
   wire [2:0] f_rs3 = instr[6:4];
   wire [2:0] f_rb3 = instr[9:7]; // Store base sits clear of the offset bits
   wire [4:0] f_r5a = instr[9:5];
   wire [4:0] f_r5b = instr[4:0];
   // 32-bit form fields
   wire [4:0] f_rt32 = instr[25:21];
   wire [4:0] f_rs32 = instr[20:16];
   wire [4:0] f_rd32 = instr[15:11];

   // Mapped register numbers and expanded immediates
   wire [4:0] map_rd;
   wire [4:0] map_rs;
   wire [4:0] map_rb;
   wire [4:0] map_st;
   wire [31:0] add_val;
   wire [31:0] mask_val;

   // ==================================================
   // Register code maps
   cod_reg_map u_map_rd (
      .code(f_rd3),
      .store_src(1'b0),
      .reg_num(map_rd)
   );
   cod_reg_map u_map_rs (
      .code(f_rs3),
      .store_src(1'b0),
      .reg_num(map_rs)
   );
   cod_reg_map u_map_rb (
      .code(f_rb3),
      .store_src(1'b0),
      .reg_num(map_rb)
   );
   cod_reg_map u_map_st (
      .code(f_rs3),
      .store_src(1'b1),
      .reg_num(map_st)
   );

   // Immediate tables
   cod_imm_expand u_imm (
      .add_code(instr[3:1]),
      .mask_code(instr[3:0]),
      .add_val(add_val),
      .mask_val(mask_val)
   );

   // Next values of the output registers
   reg [4:0] nxt_src_a;
   reg [4:0] nxt_src_b;
   reg [4:0] nxt_dest;
   reg nxt_dest_we;
   reg [1:0] nxt_src_sel;
   reg [31:0] nxt_imm;
   reg [4:0] nxt_imm_shift;
   reg [4:0] nxt_index_shift;
   reg nxt_no_delay;
   reg nxt_link_we;

   // ==================================================
   // Per-operation operand decode
   always @* begin
      // Start from an unknown op: no operands and no writes
      nxt_src_a = `COD_REG_ZERO;
      nxt_src_b = `COD_REG_ZERO;
      nxt_dest = `COD_REG_ZERO;
      nxt_dest_we = 1'b0;
      nxt_src_sel = `COD_SRC_GPR;
      nxt_imm = 32'h00000000;
      nxt_imm_shift = 5'h00;
      nxt_index_shift = 5'h00;
      nxt_no_delay = 1'b0;
      nxt_link_we = 1'b0;
      case (op)
         // Two-register add with coded immediate
         `COD_OP_ADDI2: begin
            nxt_src_a = map_rs; // RQ1
            nxt_dest = map_rd; // RQ1
            nxt_dest_we = 1'b1;
            nxt_imm = add_val; // RQ8 RQ16
         end

         // Mask immediate from the sixteen-entry table
         `COD_OP_MASKI: begin
            nxt_src_a = map_rs; // RQ1
            nxt_dest = map_rd;
            nxt_dest_we = 1'b1;
            nxt_imm = mask_val; // RQ9 RQ16
         end

         // Compact stores: base, source from the store set, offset
         `COD_OP_SB, `COD_OP_SH, `COD_OP_SW: begin
            nxt_src_a = map_rb; // RQ1
            nxt_src_b = map_st; // RQ2
            nxt_imm = {28'h0000000, instr[3:0]}; // RQ16
            // Offset scales with access size
            if (op == `COD_OP_SH)
               nxt_imm_shift = `COD_SHIFT_HALF;
            else if (op == `COD_OP_SW)
               nxt_imm_shift = `COD_SHIFT_WORD;
         end

         // Register copy names any register on both sides
         `COD_OP_COPY: begin
            nxt_dest = f_r5a; // RQ3 RQ13
            nxt_src_a = f_r5b; // RQ3 RQ13
            nxt_dest_we = 1'b1;
         end

         // Register jump through a full 5-bit field
         `COD_OP_JR16: begin
            nxt_src_a = f_r5b; // RQ4 RQ13
         end

         // Compact call links into the return register
         `COD_OP_JALRS16: begin
            nxt_src_a = f_r5b; // RQ4
            nxt_dest = `COD_REG_RA; // RQ5
            nxt_link_we = 1'b1; // RQ11
         end

         // Stack-relative word access; offset counts words
         `COD_OP_LOAD_WORD_STACK_REL, `COD_OP_STORE_WORD_STACK_REL: begin
            nxt_src_a = `COD_REG_SP; // RQ5
            if (op == `COD_OP_LOAD_WORD_STACK_REL) begin
               nxt_dest = f_r5a; // RQ4 RQ13
               nxt_dest_we = 1'b1;
            end else begin
               nxt_src_b = f_r5a; // RQ4
            end
            nxt_imm = {27'h0000000, instr[4:0]}; // RQ16
            nxt_imm_shift = `COD_SHIFT_WORD; // RQ15
         end

         // Product reads take a special word, not a register
         `COD_OP_RDUP, `COD_OP_RDBOT: begin
            nxt_dest = f_r5b; // RQ4
            nxt_dest_we = 1'b1;
            nxt_src_sel = (op == `COD_OP_RDUP) ? `COD_SRC_UPPER : `COD_SRC_BOTTOM; // RQ7
         end

         // Load relative to the global base pointer
         `COD_OP_LWGP: begin
            nxt_src_a = `COD_REG_GP; // RQ5
            nxt_dest = map_rd;
            nxt_dest_we = 1'b1;
            nxt_imm = sext({16'h0000, instr[6:0]}, 5'h07); // RQ16
            nxt_imm_shift = `COD_SHIFT_WORD;
         end

         // Compact zero test branch on a 3-bit register
         `COD_OP_BEQZ16: begin
            nxt_src_a = map_rd; // RQ1
            nxt_imm = sext({16'h0000, instr[6:0]}, 5'h07); // RQ16
            nxt_imm_shift = `COD_SHIFT_HALF; // RQ14
         end

         // Compact unconditional branch, 10-bit offset
         `COD_OP_B16: begin
            nxt_imm = sext({13'h0000, instr[9:0]}, 5'h0a); // RQ16
            nxt_imm_shift = `COD_SHIFT_HALF; // RQ14
         end

         // 32-bit zero test branches; nothing issues in a slot
         `COD_OP_BRANCH_ZERO_NODELAY, `COD_OP_BRANCH_NONZERO_NODELAY: begin
            nxt_src_a = f_rs32; // RQ10 RQ13
            nxt_imm = sext({7'h00, instr[15:0]}, 5'h10); // RQ10 RQ16
            nxt_imm_shift = `COD_SHIFT_HALF; // RQ14
            nxt_no_delay = 1'b1; // RQ10
         end

         // 32-bit calls; the barrier form decodes the same here
         `COD_OP_CALL_REG_SHORT_SLOT, `COD_OP_JALRSHB: begin
            nxt_src_a = f_rs32; // RQ13
            nxt_dest = f_rt32; // RQ13
            nxt_link_we = 1'b1; // RQ11
         end

         // Scaled indexed load: index counts words
         `COD_OP_LOAD_WORD_SCALED_INDEX: begin
            nxt_src_a = f_rs32; // RQ12 RQ13
            nxt_src_b = f_rt32; // RQ12
            nxt_dest = f_rd32; // RQ12
            nxt_dest_we = 1'b1;
            nxt_index_shift = `COD_SHIFT_WORD; // RQ12
         end

         // PC-relative add; the pc itself is the source
         `COD_OP_ADDIPC: begin
            nxt_src_sel = `COD_SRC_PC; // RQ6
            nxt_dest = map_rd; // RQ6
            nxt_dest_we = 1'b1;
            nxt_imm = sext(instr[22:0], 5'h17); // RQ6 RQ16
            nxt_imm_shift = `COD_SHIFT_WORD;
         end

         // Unknown op codes decode to nothing
         default: begin
            nxt_src_a = `COD_REG_ZERO;
         end
      endcase
   end

   // ==================================================
   // Output registers; link is pc of call plus call and short slot
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_valid_ff <= 1'b0;
         src_a_ff <= 5'h00;
         src_b_ff <= 5'h00;
         dest_ff <= 5'h00;
         dest_we_ff <= 1'b0;
         src_sel_ff <= 2'h0;
         imm_ff <= 32'h00000000;
         imm_shift_ff <= 5'h00;
         index_shift_ff <= 5'h00;
         no_delay_slot_ff <= 1'b0;
         link_addr_ff <= 32'h00000000;
         link_we_ff <= 1'b0;
      end else begin
         // Operands follow fetch every cycle; only valid and writes are gated
         out_valid_ff <= in_valid;
         src_a_ff <= nxt_src_a;
         src_b_ff <= nxt_src_b;
         dest_ff <= nxt_dest;
         dest_we_ff <= nxt_dest_we & in_valid;
         src_sel_ff <= nxt_src_sel;
         imm_ff <= nxt_imm;
         imm_shift_ff <= nxt_imm_shift;
         index_shift_ff <= nxt_index_shift;
         no_delay_slot_ff <= nxt_no_delay;
         // Short slot: 32-bit call adds 4+2, 16-bit call adds 2+2
         if (op == `COD_OP_JALRS16)
            link_addr_ff <= pc + `COD_LINK_SHORT + `COD_LINK_SHORT; // RQ11
         else
            link_addr_ff <= pc + 32'h00000004 + `COD_LINK_SHORT; // RQ11
         link_we_ff <= nxt_link_we & in_valid;
      end
   end
endmodule // cod_decoder

// ===== tb/cod_fetch_model.sv
// Purpose: fetch stage model feeding the operand decoder
// Assumes: the bench calls its tasks just after a falling edge
// Notes: an idle word is inverted so stale fields are never trusted
`timescale 1ns/1ns
module cod_fetch_model (
   // To decoder
   output reg in_valid,
   output reg [4:0] op,
   output reg [31:0] instr,
   output reg [31:0] pc
);
   // ==========================================
   // Quiet bus at time zero
   initial begin
      in_valid = 1'b0;
      op = 5'h00;
      instr = 32'h00000000;
      pc = 32'h00000000;
   end
   // One fetched word, held until the next call
   task issue(input v, input [4:0] o, input [31:0] w, input [31:0] a);
      begin
         in_valid = v;
         op = o;
         instr = w;
         pc = a;
      end
   endtask
   // Released bus shows the inverse, not the old word
   task idle;
      begin
         in_valid = 1'b0;
         instr = ~instr;
      end
   endtask
endmodule // cod_fetch_model

// ===== tb/cod_chk.sv
// Purpose: port checks on the operand decoder
// Assumes: every output answers the word taken one edge before
// Notes: lop_ff is none after reset, so no check looks into reset
`timescale 1ns/1ns
`include "cod_defs.vh"
module cod_chk (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Fetch side
   input wire in_valid,
   input wire [4:0] op,
   input wire [31:0] instr,
   input wire [31:0] pc,
   // Decoded side
   input wire [4:0] src_a_ff,
   input wire [4:0] src_b_ff,
   input wire [4:0] dest_ff,
   input wire [1:0] src_sel_ff,
   input wire [31:0] imm_ff,
   input wire [4:0] imm_shift_ff,
   input wire [4:0] index_shift_ff,
   input wire no_delay_slot_ff,
   input wire [31:0] link_addr_ff,
   input wire link_we_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   reg [4:0] lop_ff;
   // ==========================================
   // Op whose result stands now
   always @(posedge clk or posedge rst) begin
      if (rst) lop_ff <= `COD_OP_NONE;
      else lop_ff <= op;
   end
   // Compact sets: usual and store source
   function [4:0] m3(input [2:0] c);
      m3 = (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
   endfunction
   function [4:0] s3(input [2:0] c);
      s3 = (c == 3'h1) ? 5'h11 : {2'h0, c};
   endfunction
   // ==========================================
   // Checks
   a_short_map:
   assert property (lop_ff == `COD_OP_ADDI2 |-> dest_ff == m3($past(instr[9:7]))
      && src_a_ff == m3($past(instr[6:4]))) else $error("short register map wrong");
   a_store_src:
   assert property (lop_ff == `COD_OP_SW |-> src_b_ff == s3($past(instr[6:4]))
      && src_a_ff == m3($past(instr[9:7]))) else $error("store source wrong");
   a_copy_full:
   assert property (lop_ff == `COD_OP_COPY |-> {dest_ff, src_a_ff} == $past(instr[9:0]))
      else $error("copy registers wrong");
   a_implicit_reg:
   assert property (lop_ff == `COD_OP_LWGP |-> src_a_ff == `COD_REG_GP)
      else $error("global base not used");
   a_pc_source:
   assert property (lop_ff == `COD_OP_ADDIPC |-> src_sel_ff == `COD_SRC_PC
      && imm_ff == {{9{$past(instr[22])}}, $past(instr[22:0])}) else $error("pc add wrong");
   a_product_sel:
   assert property (lop_ff == `COD_OP_RDUP || lop_ff == `COD_OP_RDBOT |-> src_sel_ff ==
      (lop_ff == `COD_OP_RDUP ? `COD_SRC_UPPER : `COD_SRC_BOTTOM)) else $error("product word");
   a_nodelay_br:
   assert property (lop_ff == `COD_OP_BRANCH_NONZERO_NODELAY |-> no_delay_slot_ff && imm_shift_ff ==
      `COD_SHIFT_HALF && imm_ff == {{16{$past(instr[15])}}, $past(instr[15:0])})
      else $error("branch without slot wrong");
   a_link_short:
   assert property (lop_ff == `COD_OP_JALRSHB |-> link_addr_ff == $past(pc) + 32'h6
      && link_we_ff == $past(in_valid)) else $error("call link wrong");
   a_scaled_idx:
   assert property (lop_ff == `COD_OP_LOAD_WORD_SCALED_INDEX |-> index_shift_ff == `COD_SHIFT_WORD
      && {src_b_ff, src_a_ff, dest_ff} == $past(instr[25:11])) else $error("scaled load");
   a_stack_shift:
   assert property (lop_ff == `COD_OP_STORE_WORD_STACK_REL |-> imm_shift_ff == `COD_SHIFT_WORD
      && src_a_ff == `COD_REG_SP) else $error("stack store wrong");
endmodule // cod_chk
bind cod_decoder cod_chk u_chk (.clk(clk), .rst(rst), .in_valid(in_valid), .op(op),
   .instr(instr), .pc(pc), .src_a_ff(src_a_ff), .src_b_ff(src_b_ff), .dest_ff(dest_ff),
   .src_sel_ff(src_sel_ff), .imm_ff(imm_ff), .imm_shift_ff(imm_shift_ff),
   .index_shift_ff(index_shift_ff), .no_delay_slot_ff(no_delay_slot_ff),
   .link_addr_ff(link_addr_ff), .link_we_ff(link_we_ff));

// ===== tb/cod_decoder_tb.sv
// Purpose: self-checking bench for the operand decoder
// Assumes: one word a cycle, result one edge later
// Notes: every op code, unknown ones too, gets eight random words
`timescale 1ns/1ns
`include "cod_defs.vh"
module cod_decoder_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   wire in_valid, out_valid_ff, dest_we_ff, no_delay_slot_ff, link_we_ff;
   wire [4:0] op, src_a_ff, src_b_ff, dest_ff, imm_shift_ff, index_shift_ff;
   wire [1:0] src_sel_ff;
   wire [31:0] instr, pc, imm_ff, link_addr_ff;
   integer num_errors = 0;
   integer comparisons = 0;
   integer i, k;
   reg p_val = 1'b0;
   reg [4:0] p_op = 5'h00;
   reg [31:0] p_ins = 32'h0;
   reg [31:0] p_pc = 32'h0;
   // Immediate tables, code 0 in the low slot
   localparam [63:0] ADD_T = {8'h18, 8'h14, 8'h10, 8'h0c, 8'h08, 8'h04, 8'h01, 8'hff};
   localparam [255:0] MSK_T = {16'hffff, 16'h8000, 16'h00ff, 16'h0080, 16'h0040,
      16'h003f, 16'h0020, 16'h001f, 16'h0010, 16'h000f, 16'h0008, 16'h0007, 16'h0004,
      16'h0003, 16'h0002, 16'h0001};
   // ==========================================
   // Clock and parts
   always #5 clk = ~clk;
   cod_fetch_model F (.in_valid(in_valid), .op(op), .instr(instr), .pc(pc));
   cod_decoder DUT (.clk(clk), .rst(rst), .in_valid(in_valid), .op(op), .instr(instr),
      .pc(pc), .out_valid_ff(out_valid_ff), .src_a_ff(src_a_ff), .src_b_ff(src_b_ff),
      .dest_ff(dest_ff), .dest_we_ff(dest_we_ff), .src_sel_ff(src_sel_ff), .imm_ff(imm_ff),
      .imm_shift_ff(imm_shift_ff), .index_shift_ff(index_shift_ff),
      .no_delay_slot_ff(no_delay_slot_ff), .link_addr_ff(link_addr_ff),
      .link_we_ff(link_we_ff));
   // ==========================================
   // Compare and close
   task cmp5(input [4:0] g, input [4:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task cmp32(input [31:0] g, input [31:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task complete_run;
      begin
         $display("errors %0d comparisons %0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   function [4:0] s3(input [2:0] c);
      s3 = (c == 3'h1) ? 5'h11 : {2'h0, c};
   endfunction
   function [4:0] m3(input [2:0] c);
      m3 = (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
   endfunction
   // ==========================================
   // Model: expected result of the previous word
   task check_prev;
      begin
         cmp5({4'h0, out_valid_ff}, {4'h0, p_val});
         case (p_op)
            `COD_OP_ADDI2: begin
               cmp5(dest_ff, m3(p_ins[9:7]));
               cmp32(imm_ff, {{24{ADD_T[p_ins[3:1]*8+7]}}, ADD_T[p_ins[3:1]*8 +: 8]});
            end
            `COD_OP_MASKI: cmp32(imm_ff, {16'h0, MSK_T[p_ins[3:0]*16 +: 16]});
            `COD_OP_COPY: cmp5(dest_ff, p_ins[9:5]);
            `COD_OP_JR16: cmp5(src_a_ff, p_ins[4:0]);
            `COD_OP_LOAD_WORD_STACK_REL: cmp5(imm_shift_ff, `COD_SHIFT_WORD);
            `COD_OP_RDUP: cmp5({3'h0, src_sel_ff}, {3'h0, `COD_SRC_UPPER});
            `COD_OP_RDBOT: cmp5(dest_ff, p_ins[4:0]);
            `COD_OP_LWGP: cmp5(src_a_ff, `COD_REG_GP);
            `COD_OP_BEQZ16: cmp5(src_a_ff, m3(p_ins[9:7]));
            `COD_OP_B16: cmp5(imm_shift_ff, `COD_SHIFT_HALF);
            `COD_OP_BRANCH_ZERO_NODELAY: cmp5({4'h0, no_delay_slot_ff}, 5'h01);
            `COD_OP_CALL_REG_SHORT_SLOT: cmp32(link_addr_ff, p_pc + 32'h6);
            `COD_OP_LOAD_WORD_SCALED_INDEX: cmp5(src_a_ff, p_ins[20:16]);
            `COD_OP_ADDIPC: cmp32(imm_ff, {{9{p_ins[22]}}, p_ins[22:0]});
            `COD_OP_JALRS16: begin
               cmp5(dest_ff, `COD_REG_RA);
               cmp32(link_addr_ff, p_pc + 32'h4);
            end
            `COD_OP_SB, `COD_OP_SH, `COD_OP_SW: begin
               cmp5(src_a_ff, m3(p_ins[9:7]));
               cmp5(src_b_ff, s3(p_ins[6:4]));
            end
            `COD_OP_STORE_WORD_STACK_REL: cmp5(src_b_ff, p_ins[9:5]);
            `COD_OP_BRANCH_NONZERO_NODELAY: cmp5(imm_shift_ff, `COD_SHIFT_HALF);
            `COD_OP_JALRSHB: cmp32(link_addr_ff, p_pc + 32'h6);
            default: cmp5({3'h0, dest_we_ff, link_we_ff}, 5'h00);
         endcase
      end
   endtask
   // ==========================================
   // Main sequence: all op codes back to back
   initial begin
      i = $urandom(32'h30845a37);
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      for (k = 0; k < 32; k = k + 1) begin
         for (i = 0; i < 8; i = i + 1) begin
            @(negedge clk);
            check_prev;
            p_op = k[4:0];
            p_ins = $urandom;
            p_pc = $urandom;
            p_val = $urandom;
            F.issue(p_val, p_op, p_ins, p_pc);
         end
      end
      @(negedge clk);
      check_prev;
      F.idle;
      complete_run;
   end
   // Hang guard, well past the 265 cycles needed
   initial begin
      #20000;
      num_errors = num_errors + 1;
      complete_run;
   end
endmodule // cod_decoder_tb
